// File: design/uer_pkg.sv
package uer_pkg;

  // Register addresses on the three address lines
  localparam logic [2:0] ADDR_0 = 3'h0;
  localparam logic [2:0] ADDR_1 = 3'h1;
  localparam logic [2:0] ADDR_2 = 3'h2;
  localparam logic [2:0] ADDR_3 = 3'h3;
  localparam logic [2:0] ADDR_4 = 3'h4;
  localparam logic [2:0] ADDR_5 = 3'h5;
  localparam logic [2:0] ADDR_6 = 3'h6;
  localparam logic [2:0] ADDR_7 = 3'h7;

  // Line control key value and field positions
  localparam logic [7:0] LCR_ENH_KEY  = 8'hBF;
  localparam int         LCR_DIV_BIT  = 7;
  localparam int         EFR_EXT_BIT  = 4;
  localparam int         FCR_EN_BIT   = 0;
  localparam int         FCR_RXRST_BIT = 1;
  localparam int         FCR_TXRST_BIT = 2;
  localparam int         FEATURE_CONTROL_RX_BIT  = 7;
  localparam int         IER_RX_BIT   = 0;
  localparam int         IER_TX_BIT   = 1;
  localparam int         IER_LS_BIT   = 2;
  localparam int         IER_MS_BIT   = 3;
  localparam int         IER_XOFF_BIT = 5;
  localparam int         IER_RTS_BIT  = 6;
  localparam int         IER_CTS_BIT  = 7;

  // Extended bit masks, gated by the enhanced-function enable
  localparam logic [7:0] IER_EXT_MASK = 8'hF0;
  localparam logic [7:0] FCR_EXT_MASK = 8'h30;
  localparam logic [7:0] MCR_EXT_MASK = 8'hE0;
  localparam logic [7:0] ISR_EXT_MASK = 8'h30;

  // Interrupt status source codes, bits 5:0
  localparam logic [5:0] ISR_LINE    = 6'h06;
  localparam logic [5:0] ISR_TIMEOUT = 6'h0C;
  localparam logic [5:0] ISR_RXDATA  = 6'h04;
  localparam logic [5:0] ISR_TXRDY   = 6'h02;
  localparam logic [5:0] ISR_MODEM   = 6'h00;
  localparam logic [5:0] ISR_XOFF    = 6'h10;
  localparam logic [5:0] ISR_FLOW    = 6'h20;
  localparam logic [5:0] ISR_NONE    = 6'h01;

  // Reset values
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] DIV_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // Host bus pins; the four strobes are active low
  typedef struct packed {
    logic       selN;       // Chip select
    logic       readN;      // Read strobe
    logic       writeN;     // Write strobe
    logic       statusSelN; // Shared FIFO status select
    logic [2:0] addr;       // Register address
    logic [7:0] wrData;     // Write data from host
  } uer_host_type;

  // Status from the receive and transmit datapaths
  typedef struct packed {
    logic [7:0] rxCount;    // Receive FIFO fill
    logic [7:0] txCount;    // Transmit FIFO fill
    logic [7:0] rxData;     // Receive holding byte
    logic       rxLoaded;   // Pulse: character entered receive FIFO
    logic       rxTimeout;  // Receive time-out pending
    logic       txReady;    // Transmit ready level
    logic [6:0] lineUpper;  // Line status bits 7:1
    logic [7:0] modemStat;  // Modem status byte
    logic       xoffSeen;   // Pause character detected
    logic       flowEdge;   // Flow pin change pending
    logic [3:0] chanRxRdy;  // Receive ready of all four channels
    logic [3:0] chanTxRdy;  // Transmit ready of all four channels
  } uer_stat_type;

  // Control outputs toward the rest of the channel
  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0]  lineControl;
    logic [7:0]  interruptEnable;
    logic [7:0]  fifoControl;
    logic [7:0]  modemControl;
    logic [7:0]  featureControl;
    logic [7:0]  enhancedFunction;
    logic [7:0]  rxTrigger;
    logic [7:0]  txTrigger;
    logic [7:0]  resumeCharOne;
    logic [7:0]  resumeCharTwo;
    logic [7:0]  pauseCharOne;
    logic [7:0]  pauseCharTwo;
  } uer_ctrl_type;

endpackage

// File: design/uer_regs.sv
`timescale 1ns/10ps
module uer_regs
  import uer_pkg::*;
#(
  parameter logic [7:0] DEV_REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_IDENTITY = 8'h5A  // Arbitrary value
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire uer_host_type hostPins,
  input  wire uer_stat_type chanStat,
  output logic [7:0]        dataOut,
  output logic              dataOe,
  output uer_ctrl_type      ctrl,
  output logic [7:0]        txData,
  output logic              txWrite,
  output logic              rxPop,
  output logic              rxFifoReset,
  output logic              txFifoReset,
  output logic              irqOut,
  output logic              rxDataReady
);

  uer_host_type hostS1;    // First synchroniser stage
  uer_host_type hostS2;    // Second synchroniser stage
  uer_host_type hostPrev;  // Delayed copy for edge detection

  // Stored registers
  uer_ctrl_type regs;
  uer_ctrl_type next_regs;
  logic [7:0]   scratch;
  logic [7:0]   next_scratch;
  logic         txPend;        // Sticky transmit-ready interrupt
  logic         next_txPend;
  logic         txReadyPrev;   // Transmit ready one cycle earlier
  logic         dataReady;     // Receive data ready flag
  logic         next_dataReady;
  logic [7:0]   next_dataOut;
  logic         next_dataOe;
  logic [7:0]   next_txData;
  logic         next_txWrite;
  logic         next_rxPop;
  logic         next_rxFifoReset;
  logic         next_txFifoReset;

  // Decode helpers
  logic         extOn;         // Enhanced bits enabled
  logic         keyOn;         // Line control holds the enhanced key
  logic         divOn;         // Divisor access enabled
  logic         readStart;     // Falling edge of read strobe
  logic         writeEnd;      // Rising edge of write strobe
  logic         fifoOn;
  logic         rxAtTrigger;
  logic [5:0]   isrCode;
  logic [7:0]   isrByte;
  logic [7:0]   lsrByte;
  logic [7:0]   readByte;
  logic [7:0]   ierEff;
  logic [7:0]   mcrEff;

  // Two-flop synchroniser on the host pins plus an edge history stage
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hostS1   <= '1;
      hostS2   <= '1;
      hostPrev <= '1;
    end
    else
    begin
      hostS1   <= hostPins;
      hostS2   <= hostS1;
      hostPrev <= hostS2;
    end
  end

  // Mode and strobe decode
  always_comb
  begin
    extOn      = regs.enhancedFunction[EFR_EXT_BIT];
    keyOn      = (regs.lineControl == LCR_ENH_KEY);
    divOn      = regs.lineControl[LCR_DIV_BIT] && !keyOn;
    readStart  = hostPrev.readN && !hostS2.readN &&
                 (!hostS2.selN || !hostS2.statusSelN);
    writeEnd   = !hostPrev.writeN && hostS2.writeN && !hostPrev.selN;
    fifoOn     = regs.fifoControl[FCR_EN_BIT];
    ierEff     = extOn ? regs.interruptEnable
                       : (regs.interruptEnable & ~IER_EXT_MASK);
    mcrEff     = extOn ? regs.modemControl
                       : (regs.modemControl & ~MCR_EXT_MASK);
    // FIFO mode compares fill to trigger, otherwise any byte counts
    rxAtTrigger = fifoOn ? (chanStat.rxCount >= regs.rxTrigger)
                         : (chanStat.rxCount != BYTE_ZERO);
  end

  // Prioritised interrupt source from enabled pending sources
  always_comb
  begin
    if (ierEff[IER_LS_BIT] && (chanStat.lineUpper[3:0] != 4'h0))
      isrCode = ISR_LINE;
    else if (ierEff[IER_RX_BIT] && chanStat.rxTimeout)
      isrCode = ISR_TIMEOUT;
    else if (ierEff[IER_RX_BIT] && rxAtTrigger)
      isrCode = ISR_RXDATA;
    else if (ierEff[IER_TX_BIT] && txPend)
      isrCode = ISR_TXRDY;
    else if (ierEff[IER_MS_BIT] && (chanStat.modemStat[3:0] != 4'h0))
      isrCode = ISR_MODEM;
    else if (ierEff[IER_XOFF_BIT] && chanStat.xoffSeen)
      isrCode = ISR_XOFF;
    else if ((ierEff[IER_RTS_BIT] || ierEff[IER_CTS_BIT]) && chanStat.flowEdge)
      isrCode = ISR_FLOW;
    else
      isrCode = ISR_NONE;
    // FIFO enable mirrors in the top two bits; extended bits masked off when enhanced bits are disabled
    isrByte = {fifoOn, fifoOn, isrCode};
    if (!extOn)
      isrByte = isrByte & ~ISR_EXT_MASK;
    lsrByte = {chanStat.lineUpper, dataReady};
  end

  // Read data multiplexer
  always_comb
  begin
    readByte = BYTE_ZERO;
    if (!hostS2.statusSelN)
      // Address lines are ignored for the shared status byte
      readByte = {~chanStat.chanRxRdy, ~chanStat.chanTxRdy};
    else if (keyOn)
    begin
      if (hostS2.addr == ADDR_0)
        readByte = regs.featureControl[FEATURE_CONTROL_RX_BIT] ? chanStat.rxCount
                                                    : chanStat.txCount;
      else if (hostS2.addr == ADDR_1)
        readByte = regs.featureControl;
      else if (hostS2.addr == ADDR_2)
        readByte = regs.enhancedFunction;
      else if (hostS2.addr == ADDR_3)
        readByte = regs.lineControl;
      else if (hostS2.addr == ADDR_4)
        readByte = regs.resumeCharOne;
      else if (hostS2.addr == ADDR_5)
        readByte = regs.resumeCharTwo;
      else if (hostS2.addr == ADDR_6)
        readByte = regs.pauseCharOne;
      else
        readByte = regs.pauseCharTwo;
    end
    else if (divOn)
    begin
      // A zero divisor exposes the revision and identity bytes instead
      if (hostS2.addr == ADDR_0)
        readByte = (regs.divisor == DIV_RESET) ? DEV_REVISION
                                               : regs.divisor[7:0];
      else if (hostS2.addr == ADDR_1)
        readByte = (regs.divisor == DIV_RESET) ? DEV_IDENTITY
                                               : regs.divisor[15:8];
      else if (hostS2.addr == ADDR_3)
        readByte = regs.lineControl;
      else
        readByte = BYTE_ZERO;
    end
    else if (hostS2.addr == ADDR_0)
      readByte = chanStat.rxData;
    else if (hostS2.addr == ADDR_1)
      readByte = ierEff;
    else if (hostS2.addr == ADDR_2)
      readByte = isrByte;
    else if (hostS2.addr == ADDR_3)
      readByte = regs.lineControl;
    else if (hostS2.addr == ADDR_4)
      readByte = mcrEff;
    else if (hostS2.addr == ADDR_5)
      readByte = lsrByte;
    else if (hostS2.addr == ADDR_6)
      readByte = chanStat.modemStat;
    else
      readByte = scratch;
  end

  // Next values of registers, flags and bus outputs
  always_comb
  begin
    next_regs        = regs;
    next_scratch     = scratch;
    next_dataOut     = dataOut;
    next_dataOe      = dataOe;
    next_txData      = txData;
    next_txWrite     = 1'b0;
    next_rxPop       = 1'b0;
    next_rxFifoReset = 1'b0;
    next_txFifoReset = 1'b0;
    next_txPend      = txPend;

    // Read cycle: capture data at strobe fall, release bus at strobe rise
    if (readStart)
    begin
      next_dataOut = readByte;
      next_dataOe  = 1'b1;
      // Holding register read pops one byte
      if (hostS2.statusSelN && !keyOn && !divOn && hostS2.addr == ADDR_0)
        next_rxPop = 1'b1;
      // Status read acknowledges a shown transmit-ready source
      if (hostS2.statusSelN && !keyOn && !divOn && hostS2.addr == ADDR_2 &&
          isrCode == ISR_TXRDY)
        next_txPend = 1'b0;
    end
    else if (hostS2.readN)
      next_dataOe = 1'b0;

    // Write cycle, taken at the rising edge of the write strobe
    if (writeEnd)
    begin
      if (hostPrev.addr == ADDR_3)
        next_regs.lineControl = hostPrev.wrData;
      else if (keyOn)
      begin
        if (hostPrev.addr == ADDR_0)
        begin
          // Trigger write goes to the table chosen by the feature control
          if (regs.featureControl[FEATURE_CONTROL_RX_BIT])
            next_regs.rxTrigger = hostPrev.wrData;
          else
            next_regs.txTrigger = hostPrev.wrData;
        end
        else if (hostPrev.addr == ADDR_1)
          next_regs.featureControl = hostPrev.wrData;
        else if (hostPrev.addr == ADDR_2)
          next_regs.enhancedFunction = hostPrev.wrData;
        else if (hostPrev.addr == ADDR_4)
          next_regs.resumeCharOne = hostPrev.wrData;
        else if (hostPrev.addr == ADDR_5)
          next_regs.resumeCharTwo = hostPrev.wrData;
        else if (hostPrev.addr == ADDR_6)
          next_regs.pauseCharOne = hostPrev.wrData;
        else
          next_regs.pauseCharTwo = hostPrev.wrData;
      end
      else if (divOn)
      begin
        if (hostPrev.addr == ADDR_0)
          next_regs.divisor[7:0] = hostPrev.wrData;
        else if (hostPrev.addr == ADDR_1)
          next_regs.divisor[15:8] = hostPrev.wrData;
      end
      else if (hostPrev.addr == ADDR_0)
      begin
        // Transmit holding write also clears the transmit-ready source
        next_txData  = hostPrev.wrData;
        next_txWrite = 1'b1;
        next_txPend  = 1'b0;
      end
      else if (hostPrev.addr == ADDR_1)
        next_regs.interruptEnable = extOn ? hostPrev.wrData
            : ((hostPrev.wrData & ~IER_EXT_MASK) |
               (regs.interruptEnable & IER_EXT_MASK));
      else if (hostPrev.addr == ADDR_2)
      begin
        // Other bits program only together with the enable bit
        if (hostPrev.wrData[FCR_EN_BIT])
        begin
          next_regs.fifoControl = extOn ? hostPrev.wrData
              : ((hostPrev.wrData & ~FCR_EXT_MASK) |
                 (regs.fifoControl & FCR_EXT_MASK));
          next_rxFifoReset = hostPrev.wrData[FCR_RXRST_BIT];
          next_txFifoReset = hostPrev.wrData[FCR_TXRST_BIT];
        end
        else
          next_regs.fifoControl = REG_RESET;
      end
      else if (hostPrev.addr == ADDR_4)
        next_regs.modemControl = extOn ? hostPrev.wrData
            : ((hostPrev.wrData & ~MCR_EXT_MASK) |
               (regs.modemControl & MCR_EXT_MASK));
      else if (hostPrev.addr == ADDR_7)
        next_scratch = hostPrev.wrData;
    end

    // New transmit-ready edge wins over any clear in the same cycle
    if (chanStat.txReady && !txReadyPrev)
      next_txPend = 1'b1;

    // Load wins over the empty clear
    if (chanStat.rxLoaded)
      next_dataReady = 1'b1;
    else if (chanStat.rxCount == BYTE_ZERO)
      next_dataReady = 1'b0;
    else
      next_dataReady = dataReady;
  end

  // Register stage for all state of the block except the host pin synchroniser
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regs        <= '0;
      scratch     <= REG_RESET;
      dataOut     <= REG_RESET;
      dataOe      <= 1'b0;
      txData      <= REG_RESET;
      txWrite     <= 1'b0;
      rxPop       <= 1'b0;
      rxFifoReset <= 1'b0;
      txFifoReset <= 1'b0;
      txPend      <= 1'b0;
      txReadyPrev <= 1'b0;
      dataReady   <= 1'b0;
    end
    else
    begin
      regs        <= next_regs;
      scratch     <= next_scratch;
      dataOut     <= next_dataOut;
      dataOe      <= next_dataOe;
      txData      <= next_txData;
      txWrite     <= next_txWrite;
      rxPop       <= next_rxPop;
      rxFifoReset <= next_rxFifoReset;
      txFifoReset <= next_txFifoReset;
      txPend      <= next_txPend;
      txReadyPrev <= chanStat.txReady;
      dataReady   <= next_dataReady;
    end
  end

  // Effective control outputs; extended bits masked when disabled
  always_comb
  begin
    ctrl                 = regs;
    ctrl.interruptEnable = ierEff;
    ctrl.modemControl    = mcrEff;
    ctrl.fifoControl     = extOn ? regs.fifoControl
                                 : (regs.fifoControl & ~FCR_EXT_MASK);
  end

  // Interrupt follows the status code level, so it drops with the source
  assign irqOut      = (isrCode != ISR_NONE);
  assign rxDataReady = dataReady;

endmodule // uer_regs

// File: tb/tb_uart_enhanced_register_map.sv
`timescale 1ns/10ps
// Self-checking bench for the register block
module tb_uart_enhanced_register_map
  import uer_pkg::*;
();
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  localparam logic [7:0] IDN = 8'hA7; // Arbitrary value
  logic         sys_clk;     // System clock
  logic         rst;         // Asynchronous reset
  uer_host_type hostPins;    // Host bus pins
  uer_stat_type chanStat;    // Channel status from the bench
  logic [7:0]   dataOut;     // Read data
  logic         dataOe;      // Read drive enable
  uer_ctrl_type ctrl;        // Configuration outputs
  logic         irqOut;      // Interrupt line
  logic         rxDataReady; // Receive data ready
  int           num_errors;  // Mismatches
  int           tests_run;   // Comparisons
  int           cycles;      // Watchdog
  logic [7:0]   lfsrState;   // Random source
  logic [7:0]   r1;          // Random byte
  logic [7:0]   r2;          // Random byte
  int           trig;        // Model of the receive trigger
  int           lv[4];       // FIFO fill steps
  logic [7:0]   ierTab[5];   // Enable patterns
  logic [7:0]   isrTab[5];   // Expected status per pattern
  logic [7:0]   expQ[$];     // Expected read data
  logic [7:0]   txData;      // Transmit holding byte
  logic         txWrite;     // Transmit write pulse
  logic         rxPop;       // Receive pop pulse
  logic         rxFifoReset; // Receive FIFO reset pulse
  logic         txFifoReset; // Transmit FIFO reset pulse
  int           popCnt = 0;  // Pops seen
  int           wrCnt = 0;   // Transmit writes seen
  int           rstCnt = 0;  // FIFO reset pulses seen

  uer_regs #(.DEV_REVISION(REV), .DEV_IDENTITY(IDN)) u_uer_regs (.sys_clk(sys_clk),
    .rst(rst), .hostPins(hostPins), .chanStat(chanStat), .dataOut(dataOut),
    .dataOe(dataOe), .ctrl(ctrl), .txData(txData), .txWrite(txWrite), .rxPop(rxPop),
    .rxFifoReset(rxFifoReset), .txFifoReset(txFifoReset), .irqOut(irqOut),
    .rxDataReady(rxDataReady));
  uer_host_model u_uer_host_model (.sys_clk(sys_clk), .dataOut(dataOut), .dataOe(dataOe),
    .hostPins(hostPins));

  // Clock, 5 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Eight-bit shift register step
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Register write through the host model
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_uer_host_model.cyc(a, d, 1'b1 ^ 1'b1, 1'b0, q);
  endtask

  // Register read against the expected queue
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input bit fs = 0);
    logic [7:0] q;
    expQ.push_back(e);
    u_uer_host_model.cyc(a, 8'h00, 1'b1, fs, q);
    check(q, expQ.pop_front(), "read");
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Count the one-cycle strobes at the falling edge, where they are settled
  always @(negedge sys_clk)
  begin
    if (rxPop === 1'b1)
      popCnt++;
    if (txWrite === 1'b1)
      wrCnt++;
    if (rxFifoReset === 1'b1)
      rstCnt++;
    if (txFifoReset === 1'b1)
      rstCnt++;
  end

  // Watchdog against a hung handshake
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    chanStat = '0;
    lfsrState = 8'h23;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    // Divisor bytes open, revision and identity when zero
    lfsrState = lfsr_next(lfsrState);
    r1 = lfsrState;
    lfsrState = lfsr_next(lfsrState);
    r2 = lfsrState;
    wr(ADDR_3, 8'h80);
    wr(ADDR_0, r1);
    wr(ADDR_1, r2);
    rd(ADDR_0, r1);
    rd(ADDR_1, r2);
    rd(ADDR_2, 8'h00);
    wr(ADDR_0, 8'h00);
    wr(ADDR_1, 8'h00);
    rd(ADDR_0, REV);
    rd(ADDR_1, IDN);
    // Keyed map: trigger, count, feature, enhanced, flow characters
    trig = 4;
    chanStat.rxCount = 8'h03;
    wr(ADDR_3, LCR_ENH_KEY);
    wr(ADDR_1, 8'h80);
    wr(ADDR_0, 8'(trig));
    check(ctrl.divisor, 16'h0000, "divisor");
    check(ctrl.rxTrigger, 16'(trig), "trigger");
    rd(ADDR_0, 8'h03);
    rd(ADDR_1, 8'h80);
    wr(ADDR_2, 8'h00);
    rd(ADDR_2, 8'h00);
    for (int a = 4; a < 8; a++)
    begin
      lfsrState = lfsr_next(lfsrState);
      wr(3'(a), lfsrState);
      rd(3'(a), lfsrState);
    end
    // Extended enable bits refused, then accepted
    wr(ADDR_3, 8'h03);
    wr(ADDR_1, 8'hFF);
    rd(ADDR_1, 8'h0F);
    wr(ADDR_3, LCR_ENH_KEY);
    wr(ADDR_2, 8'h10);
    rd(ADDR_2, 8'h10);
    wr(ADDR_3, 8'h03);
    wr(ADDR_1, 8'hF0);
    rd(ADDR_1, 8'hF0);
    // Receive FIFO trigger up and down
    wr(ADDR_2, 8'h01);
    wr(ADDR_1, 8'h01);
    lv = '{3, 4, 6, 3};
    foreach (lv[i])
    begin
      chanStat.rxCount = 8'(lv[i]);
      @(negedge sys_clk);
      check(irqOut, 16'(lv[i] >= trig), "rx irq");
      rd(ADDR_2, (lv[i] >= trig) ? 8'hC4 : 8'hC1);
    end
    // Line, receive data, transmit and modem sources alone behind their enable bits
    chanStat.lineUpper = 7'h01;
    chanStat.modemStat = 8'h01;
    chanStat.rxCount = 8'h06;
    chanStat.txReady = 1'b1;
    ierTab = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h02};
    isrTab = '{8'hC1, 8'hC4, 8'hC6, 8'hC0, 8'hC2};
    foreach (ierTab[i])
    begin
      wr(ADDR_1, ierTab[i]);
      check(irqOut, 16'(ierTab[i] != 8'h00), "irq mask");
      rd(ADDR_2, isrTab[i]);
    end
    // Data ready set on load, held while data remains
    chanStat = '0;
    chanStat.chanRxRdy = 4'hA;
    chanStat.chanTxRdy = 4'h3;
    @(negedge sys_clk);
    chanStat.rxLoaded = 1'b1;
    chanStat.rxCount = 8'h02;
    @(negedge sys_clk);
    chanStat.rxLoaded = 1'b0;
    check(rxDataReady, 16'h0001, "ready set");
    rd(ADDR_5, 8'h01);
    chanStat.rxCount = 8'h00;
    repeat (2) @(negedge sys_clk);
    check(rxDataReady, 16'h0000, "ready clear");
    // Holding read pops, holding write launches, FIFO resets pulse once
    lfsrState = lfsr_next(lfsrState);
    chanStat.rxData = lfsrState;
    rd(ADDR_0, lfsrState);
    check(16'(popCnt), 16'h0001, "pop");
    r1 = ~lfsrState;
    wr(ADDR_0, r1);
    check(16'(txData), 16'(r1), "tx data");
    check(16'(wrCnt), 16'h0001, "tx write");
    wr(ADDR_2, 8'h07);
    check(16'(rstCnt), 16'h0002, "fifo resets");
    // Shared FIFO status ignores the address lines
    lfsrState = lfsr_next(lfsrState);
    rd(lfsrState[2:0], 8'h5C, 1'b1);
    finish_test();
  end
endmodule // tb_uart_enhanced_register_map

// File: tb/uer_host_model.sv
`timescale 1ns/10ps
// Host processor model driving the parallel register bus
module uer_host_model
  import uer_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  output uer_host_type    hostPins
);
  // Strobes idle high from time zero
  initial hostPins = {4'hF, 3'h0, 8'h00};

  // One bus cycle, strobe held four edges and until read data is taken
  task automatic cyc(input logic [2:0] a, input logic [7:0] d, input bit rd,
                     input bit fs, output logic [7:0] q);
    int n;
    bit got;
    n = 0;
    got = 0;
    q = 8'hXX;
    @(negedge sys_clk);
    hostPins.addr = a;
    hostPins.wrData = d;
    hostPins.selN = fs;
    hostPins.statusSelN = !fs;
    hostPins.readN = !rd;
    hostPins.writeN = rd;
    // Read data taken at the edge where the drive enable shows high
    do
    begin
      @(posedge sys_clk);
      n++;
      if (rd && dataOe === 1'b1 && !got)
      begin
        q = dataOut;
        got = 1;
      end
    end
    while (n < 4 || (rd && !got && n < 20));
    @(negedge sys_clk);
    // All four strobes back to idle
    hostPins[14:11] = 4'hF;
    hostPins.wrData = ~d;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule // uer_host_model

// File: tb/uer_regs_sva.sv
`timescale 1ns/10ps
// Port checker for the register block
module uer_regs_sva
  import uer_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire uer_host_type hostPins,
  input wire uer_stat_type chanStat,
  input wire logic [7:0]   dataOut,
  input wire logic         dataOe,
  input wire uer_ctrl_type ctrl,
  input wire logic         irqOut,
  input wire logic         rxDataReady
);
  // One clock domain, reset masks every check
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Receive FIFO interrupt mode is active
  wire rxMode = ctrl.fifoControl[FCR_EN_BIT] && ctrl.interruptEnable[IER_RX_BIT];
  // Enhanced registers unlocked by the key
  wire keyOn  = ctrl.lineControl == LCR_ENH_KEY;

  a_div_locked: assert property (keyOn || !ctrl.lineControl[LCR_DIV_BIT] |=>
    $stable(ctrl.divisor)) else $error("divisor changed while closed");
  a_trig_locked: assert property (!keyOn |=> $stable(ctrl.rxTrigger))
    else $error("trigger changed without key");
  a_feat_locked: assert property (!keyOn |=> $stable(ctrl.featureControl))
    else $error("feature control changed without key");
  a_efr_locked: assert property (!keyOn |=> $stable(ctrl.enhancedFunction))
    else $error("enhanced function changed without key");
  a_ext_masked: assert property (!ctrl.enhancedFunction[EFR_EXT_BIT] |->
    ((ctrl.interruptEnable & IER_EXT_MASK) | (ctrl.fifoControl & FCR_EXT_MASK)
     | (ctrl.modemControl & MCR_EXT_MASK)) == BYTE_ZERO) else $error("extended bits set");
  a_irq_masked: assert property (ctrl.interruptEnable == BYTE_ZERO |-> !irqOut)
    else $error("interrupt with all sources masked");
  a_rx_raise: assert property (rxMode && chanStat.rxCount >= ctrl.rxTrigger |-> irqOut)
    else $error("receive interrupt missing at trigger");
  a_rx_drop: assert property (rxMode && ctrl.interruptEnable == 8'h01 && !chanStat.rxTimeout
    && chanStat.rxCount < ctrl.rxTrigger |-> !irqOut) else $error("receive interrupt below trigger");
  a_ready_set: assert property (chanStat.rxLoaded |=> rxDataReady)
    else $error("data ready not set on load");
  a_ready_keep: assert property (rxDataReady && chanStat.rxCount != BYTE_ZERO |=> rxDataReady)
    else $error("data ready cleared with data held");
  a_ready_clear: assert property (!chanStat.rxLoaded && chanStat.rxCount == BYTE_ZERO |=>
    !rxDataReady) else $error("data ready held on empty FIFO");
  a_shared_fifo_status_read: assert property ($rose(dataOe) && !hostPins.statusSelN |-> dataOut ==
    {~$past(chanStat.chanRxRdy), ~$past(chanStat.chanTxRdy)}) else $error("bad FIFO status");
endmodule // uer_regs_sva

bind uer_regs uer_regs_sva u_uer_regs_sva (.sys_clk(sys_clk), .rst(rst), .hostPins(hostPins),
  .chanStat(chanStat), .dataOut(dataOut), .dataOe(dataOe), .ctrl(ctrl), .irqOut(irqOut),
  .rxDataReady(rxDataReady));
